// ===== hdl/cpu_addr_decoder_pkg.sv
/*
 * Constants and types of the operand addressing and length decoder.
 * Assumes an 8-bit opcode split into a 3-bit mode field and 5-bit op.
 */
package cpu_addr_decoder_pkg;
    // Prebyte codes that precede an opcode
    localparam logic [7:0] Y_INDEX_PREBYTE = 8'h90;
    localparam logic [7:0] Y_INDIRECT_PREBYTE = 8'h91;
    localparam logic [7:0] INDIRECT_PREBYTE = 8'h92;
    // Opcode layout: mode field above the operation field
    localparam int MODE_FIELD_LSB = 5;
    // Mode field codes
    localparam logic [2:0] FLD_INHERENT = 3'h0, FLD_IMMEDIATE = 3'h1,
        FLD_DIR_SHORT = 3'h2, FLD_DIR_LONG = 3'h3, FLD_IDX_NONE = 3'h4,
        FLD_IDX_SHORT = 3'h5, FLD_IDX_LONG = 3'h6, FLD_RELATIVE = 3'h7;
    // Operation codes of memory forms; 00..0D also have register forms
    localparam logic [4:0] OP_LD = 5'h00, OP_LAST_REG_FORM = 5'h0D,
        OP_CP = 5'h0E, OP_SBC = 5'h16, OP_BSET = 5'h17, OP_BRES = 5'h18,
        OP_BTJT = 5'h19, OP_BTJF = 5'h1A, OP_JP = 5'h1C;
    localparam logic [3:0] INH_OP_LAST = 4'hD;
    localparam logic [4:0] REL_OP_LAST = 5'h12, REL_OP_CALL = 5'h13;
    // Instruction identifiers, 63 in all (00..3E)
    localparam logic [5:0] ID_INH_BASE = 6'h1D, ID_TRAP = 6'h1E,
        ID_WAIT_FOR_INTERRUPT = 6'h1F, ID_HALT = 6'h20,
        ID_SET_INTERRUPT_MASK = 6'h23, ID_CLEAR_INTERRUPT_MASK = 6'h24,
        ID_REL_BASE = 6'h2B, ID_RELATIVE_SUBROUTINE_CALL = 6'h3E;
    // Interrupt mask encodings I1:I0
    localparam logic [1:0] MASK_LEVEL3 = 2'h3, MASK_LEVEL0 = 2'h2;
    localparam logic [1:0] MASK_RESET = MASK_LEVEL3;
    localparam logic [7:0] PAGE_ZERO = 8'h00;
    localparam logic [2:0] LEN_ONE = 3'h1;
    localparam logic [1:0] ARG_ONE = 2'h1;

    typedef enum logic [4:0] {
        AM_INHERENT, AM_IMMEDIATE, AM_DIR_SHORT, AM_DIR_LONG, AM_IDX_NONE,
        AM_IDX_SHORT, AM_IDX_LONG, AM_IND_SHORT, AM_IND_LONG,
        AM_INDIDX_SHORT, AM_INDIDX_LONG, AM_REL_DIR, AM_REL_IND,
        AM_BIT_DIR, AM_BIT_IND, AM_BITREL_DIR, AM_BITREL_IND
    } addr_mode_t;

    typedef enum logic [3:0] {
        GRP_LOAD, GRP_STACK, GRP_INCDEC, GRP_COMPARE, GRP_LOGIC, GRP_BIT,
        GRP_BITBRANCH, GRP_ARITH, GRP_SHIFT, GRP_JUMP, GRP_CONDBR,
        GRP_INTERRUPT, GRP_FLAGS
    } group_t;

    // Functional group of each instruction identifier
    function automatic group_t group_of(input logic [5:0] id);
        case (id) inside
            [6'h00:6'h01]: group_of = GRP_LOAD;
            [6'h02:6'h03]: group_of = GRP_INCDEC;
            6'h04, [6'h0E:6'h0F]: group_of = GRP_COMPARE;
            [6'h05:6'h06], [6'h10:6'h12]: group_of = GRP_LOGIC;
            [6'h07:6'h0D]: group_of = GRP_SHIFT;
            [6'h13:6'h16], 6'h2A: group_of = GRP_ARITH;
            [6'h17:6'h18]: group_of = GRP_BIT;
            [6'h19:6'h1A]: group_of = GRP_BITBRANCH;
            [6'h1E:6'h20], 6'h22: group_of = GRP_INTERRUPT;
            [6'h23:6'h26]: group_of = GRP_FLAGS;
            [6'h27:6'h29]: group_of = GRP_STACK;
            [6'h2E:6'h3D]: group_of = GRP_CONDBR;
            default: group_of = GRP_JUMP;
        endcase
    endfunction
endpackage

// ===== hdl/cpu_addressing_mode_decoder.sv
/*
 * Operand addressing and instruction length decoder of the 8-bit core.
 * Fetches prebyte, opcode, operand bytes and pointers over a one-read
 * port on the core bus, then reports mode, effective address, length.
 * Assumes memory answers each held request with a one-cycle memAck.
 */
module cpu_addressing_mode_decoder
    import cpu_addr_decoder_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [ADDR_W-1:0] startPc,
    input wire logic [7:0] indexX,
    input wire logic [7:0] indexY,
    input wire logic memAck,
    input wire logic [7:0] memRdata,
    output logic memReq,
    output logic [ADDR_W-1:0] memAddr,
    output logic busy,
    output logic done,
    output logic illegal,
    output addr_mode_t addrMode,
    output logic [5:0] instrId,
    output group_t instrGroup,
    output logic useY,
    output logic [2:0] instrLength,
    output logic [ADDR_W-1:0] effAddr,
    output logic [7:0] immValue,
    output logic [ADDR_W-1:0] branchTarget,
    output logic [ADDR_W-1:0] nextPc,
    output logic trapReq,
    output logic waitReq,
    output logic haltReq,
    output logic [1:0] intMask
);
    // Logic is written for a 16-bit address space
    if (ADDR_W != 16) begin : g_width_check
        $error("ADDR_W must be 16");
    end

    localparam logic [ADDR_W-1:0] ADDR_ONE = {{(ADDR_W-1){1'b0}}, 1'b1};

    typedef enum logic [2:0] {
        ST_IDLE, ST_OPCODE, ST_ARG, ST_PTR_FIRST, ST_PTR_LOW, ST_FINISH
    } state_t;
    typedef enum logic [1:0] {PRE_NONE, PRE_YSEL, PRE_YIND, PRE_INDSEL} pre_t;
    typedef enum logic [1:0] {PTR_NONE, PTR_BYTE, PTR_WORD} ptr_t;

    logic rstSync1_reg, rstSync2_reg;
    state_t state_reg;
    pre_t prebyte_reg;
    addr_mode_t mode_reg;
    logic [5:0] id_reg;
    logic illegal_reg, useY_reg, memReq_reg, busy_reg;
    logic [1:0] argsLeft_reg;
    logic [2:0] lenCount_reg;
    logic [ADDR_W-1:0] fetchPc_reg, memAddr_reg, argWord_reg, ptrVal_reg;
    logic done_reg, illegalOut_reg, useYOut_reg, trap_reg, wait_reg;
    logic halt_reg;
    addr_mode_t addrMode_reg;
    logic [5:0] instrId_reg;
    group_t instrGroup_reg;
    logic [2:0] instrLength_reg;
    logic [ADDR_W-1:0] effAddr_reg, branchTarget_reg, nextPc_reg;
    logic [7:0] immValue_reg;
    logic [1:0] intMask_reg;
    logic rstInt_n;

    // Reset release through two flip-flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rstSync1_reg <= 1'b0;
            rstSync2_reg <= 1'b0;
        end else begin
            rstSync1_reg <= 1'b1;
            rstSync2_reg <= rstSync1_reg;
        end
    end
    assign rstInt_n = rstSync2_reg;

    // Operand bytes that follow the opcode for each mode
    function automatic logic [1:0] args_of(input addr_mode_t m);
        case (m)
            AM_INHERENT, AM_IDX_NONE: args_of = 2'h0;
            AM_DIR_LONG, AM_IDX_LONG: args_of = 2'h2;
            AM_BITREL_DIR, AM_BITREL_IND: args_of = 2'h2;
            default: args_of = ARG_ONE;
        endcase
    endfunction

    // Pointer read that follows the operand bytes
    function automatic ptr_t ptr_of(input addr_mode_t m);
        case (m)
            AM_IND_LONG, AM_INDIDX_LONG: ptr_of = PTR_WORD;
            AM_IND_SHORT, AM_INDIDX_SHORT, AM_REL_IND, AM_BIT_IND,
            AM_BITREL_IND: ptr_of = PTR_BYTE;
            default: ptr_of = PTR_NONE;
        endcase
    endfunction

    // Operations that have both short and long memory forms
    function automatic logic long_ok(input logic [4:0] op);
        long_ok = (op == OP_LD) || (op >= OP_CP && op <= OP_SBC);
    endfunction

    // Opcode and prebyte decode
    logic [2:0] fld;
    logic [4:0] op;
    addr_mode_t decMode;
    logic [5:0] decId;
    logic decIllegal, decUseY, isPrebyte;
    pre_t preKind;
    always_comb begin
        fld = memRdata[7:MODE_FIELD_LSB];
        op = memRdata[MODE_FIELD_LSB-1:0];
        decMode = AM_INHERENT;
        decId = {1'b0, op};
        decIllegal = 1'b0;
        decUseY = 1'b0;
        case (fld)
            FLD_INHERENT: begin
                if (!op[4] && op[3:0] <= INH_OP_LAST) begin
                    decId = ID_INH_BASE + {2'h0, op[3:0]};
                end else if (op[4] && op[3:0] <= OP_LAST_REG_FORM[3:0]) begin
                    decId = {2'h0, op[3:0]};
                end else begin
                    decIllegal = 1'b1;
                end
            end
            FLD_IMMEDIATE: begin
                decMode = AM_IMMEDIATE;
                decIllegal = !long_ok(op);
            end
            FLD_DIR_SHORT: begin
                if (op == OP_BSET || op == OP_BRES) begin
                    decMode = AM_BIT_DIR;
                end else if (op == OP_BTJT || op == OP_BTJF) begin
                    decMode = AM_BITREL_DIR;
                end else begin
                    decMode = AM_DIR_SHORT;
                end
                decIllegal = op > OP_JP;
            end
            FLD_DIR_LONG: begin
                decMode = AM_DIR_LONG;
                decIllegal = !long_ok(op);
            end
            FLD_IDX_NONE, FLD_IDX_SHORT: begin
                decMode = (fld == FLD_IDX_NONE) ? AM_IDX_NONE : AM_IDX_SHORT;
                decIllegal = op > OP_JP || (op >= OP_BSET && op <= OP_BTJF);
            end
            FLD_IDX_LONG: begin
                decMode = AM_IDX_LONG;
                decIllegal = !long_ok(op);
            end
            default: begin
                decMode = AM_REL_DIR;
                if (op <= REL_OP_LAST) begin
                    decId = ID_REL_BASE + {1'b0, op};
                end else if (op == REL_OP_CALL) begin
                    decId = ID_RELATIVE_SUBROUTINE_CALL;
                end else begin
                    decIllegal = 1'b1;
                end
            end
        endcase
        case (prebyte_reg)
            PRE_YSEL: begin
                if (decMode == AM_REL_DIR || decMode == AM_BIT_DIR ||
                        decMode == AM_BITREL_DIR) begin
                    decIllegal = 1'b1;
                end else begin
                    decUseY = 1'b1;
                end
            end
            PRE_INDSEL: begin
                case (decMode)
                    AM_DIR_SHORT: decMode = AM_IND_SHORT;
                    AM_DIR_LONG: decMode = AM_IND_LONG;
                    AM_IDX_SHORT: decMode = AM_INDIDX_SHORT;
                    AM_IDX_LONG: decMode = AM_INDIDX_LONG;
                    AM_REL_DIR: decMode = AM_REL_IND;
                    AM_BIT_DIR: decMode = AM_BIT_IND;
                    AM_BITREL_DIR: decMode = AM_BITREL_IND;
                    default: decIllegal = 1'b1;
                endcase
            end
            PRE_YIND: begin
                decUseY = 1'b1;
                case (decMode)
                    AM_IDX_SHORT: decMode = AM_INDIDX_SHORT;
                    AM_IDX_LONG: decMode = AM_INDIDX_LONG;
                    default: decIllegal = 1'b1;
                endcase
            end
            default: ;
        endcase
        isPrebyte = memRdata == Y_INDEX_PREBYTE ||
            memRdata == Y_INDIRECT_PREBYTE || memRdata == INDIRECT_PREBYTE;
        case (memRdata)
            Y_INDEX_PREBYTE: preKind = PRE_YSEL;
            Y_INDIRECT_PREBYTE: preKind = PRE_YIND;
            default: preKind = PRE_INDSEL;
        endcase
    end

    // Pointer location: bit-test forms carry it ahead of the offset
    logic [ADDR_W-1:0] argShift, ptrAddr;
    logic stopNow;
    always_comb begin
        argShift = {argWord_reg[7:0], memRdata};
        if (mode_reg == AM_BITREL_DIR || mode_reg == AM_BITREL_IND) begin
            ptrAddr = {PAGE_ZERO, argShift[15:8]};
        end else begin
            ptrAddr = {PAGE_ZERO, argShift[7:0]};
        end
        stopNow = decIllegal || (isPrebyte && prebyte_reg != PRE_NONE) ||
            args_of(decMode) == 2'h0;
    end

    // Fetch sequencer: prebyte, opcode, operands, pointer
    always_ff @(posedge clk_sys or negedge rstInt_n) begin
        if (!rstInt_n) begin
            state_reg <= ST_IDLE;
            prebyte_reg <= PRE_NONE;
            mode_reg <= AM_INHERENT;
            id_reg <= '0;
            illegal_reg <= 1'b0;
            useY_reg <= 1'b0;
            argsLeft_reg <= '0;
            lenCount_reg <= '0;
            fetchPc_reg <= '0;
            memAddr_reg <= '0;
            argWord_reg <= '0;
            ptrVal_reg <= '0;
            memReq_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        fetchPc_reg <= startPc;
                        memAddr_reg <= startPc;
                        memReq_reg <= 1'b1;
                        busy_reg <= 1'b1;
                        prebyte_reg <= PRE_NONE;
                        lenCount_reg <= '0;
                        argWord_reg <= '0;
                        ptrVal_reg <= '0;
                        state_reg <= ST_OPCODE;
                    end
                end
                ST_OPCODE: begin
                    if (memAck) begin
                        fetchPc_reg <= fetchPc_reg + ADDR_ONE;
                        lenCount_reg <= lenCount_reg + LEN_ONE;
                        memAddr_reg <= fetchPc_reg + ADDR_ONE;
                        if (isPrebyte && prebyte_reg == PRE_NONE) begin
                            prebyte_reg <= preKind;
                        end else begin
                            mode_reg <= decMode;
                            id_reg <= decId;
                            useY_reg <= decUseY;
                            illegal_reg <= decIllegal ||
                                (isPrebyte && prebyte_reg != PRE_NONE);
                            argsLeft_reg <= args_of(decMode);
                            if (stopNow) begin
                                memReq_reg <= 1'b0;
                                state_reg <= ST_FINISH;
                            end else begin
                                state_reg <= ST_ARG;
                            end
                        end
                    end
                end
                ST_ARG: begin
                    if (memAck) begin
                        argWord_reg <= argShift;
                        fetchPc_reg <= fetchPc_reg + ADDR_ONE;
                        lenCount_reg <= lenCount_reg + LEN_ONE;
                        argsLeft_reg <= argsLeft_reg - ARG_ONE;
                        if (argsLeft_reg != ARG_ONE) begin
                            memAddr_reg <= fetchPc_reg + ADDR_ONE;
                        end else if (ptr_of(mode_reg) == PTR_NONE) begin
                            memReq_reg <= 1'b0;
                            state_reg <= ST_FINISH;
                        end else begin
                            memAddr_reg <= ptrAddr;
                            state_reg <= ST_PTR_FIRST;
                        end
                    end
                end
                ST_PTR_FIRST: begin
                    if (memAck) begin
                        if (ptr_of(mode_reg) == PTR_WORD) begin
                            ptrVal_reg[15:8] <= memRdata;
                            memAddr_reg <= memAddr_reg + ADDR_ONE;
                            state_reg <= ST_PTR_LOW;
                        end else begin
                            ptrVal_reg <= {PAGE_ZERO, memRdata};
                            memReq_reg <= 1'b0;
                            state_reg <= ST_FINISH;
                        end
                    end
                end
                ST_PTR_LOW: begin
                    if (memAck) begin
                        ptrVal_reg[7:0] <= memRdata;
                        memReq_reg <= 1'b0;
                        state_reg <= ST_FINISH;
                    end
                end
                ST_FINISH: begin
                    busy_reg <= 1'b0;
                    state_reg <= ST_IDLE;
                end
                default: begin
                    memReq_reg <= 1'b0;
                    busy_reg <= 1'b0;
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Effective address and branch target formation
    logic [7:0] idxVal, relOff;
    logic [8:0] shortSum;
    logic [ADDR_W-1:0] eaNext;
    always_comb begin
        idxVal = useY_reg ? indexY : indexX;
        if (mode_reg == AM_INDIDX_SHORT) begin
            shortSum = {1'b0, ptrVal_reg[7:0]} + {1'b0, idxVal};
        end else begin
            shortSum = {1'b0, argWord_reg[7:0]} + {1'b0, idxVal};
        end
        case (mode_reg)
            AM_DIR_SHORT, AM_BIT_DIR:
                eaNext = {PAGE_ZERO, argWord_reg[7:0]};
            AM_BITREL_DIR: eaNext = {PAGE_ZERO, argWord_reg[15:8]};
            AM_DIR_LONG: eaNext = argWord_reg;
            AM_IDX_NONE: eaNext = {PAGE_ZERO, idxVal};
            AM_IDX_SHORT, AM_INDIDX_SHORT:
                eaNext = {{(ADDR_W-9){1'b0}}, shortSum};
            AM_IDX_LONG:
                eaNext = argWord_reg + {PAGE_ZERO, idxVal};
            AM_IND_SHORT, AM_BIT_IND, AM_BITREL_IND:
                eaNext = {PAGE_ZERO, ptrVal_reg[7:0]};
            AM_IND_LONG: eaNext = ptrVal_reg;
            AM_INDIDX_LONG:
                eaNext = ptrVal_reg + {PAGE_ZERO, idxVal};
            default: eaNext = '0;
        endcase
        relOff = (mode_reg == AM_REL_IND) ? ptrVal_reg[7:0] :
            argWord_reg[7:0];
    end

    // Result registers, presented with a one-cycle done pulse
    always_ff @(posedge clk_sys or negedge rstInt_n) begin
        if (!rstInt_n) begin
            done_reg <= 1'b0;
            illegalOut_reg <= 1'b0;
            useYOut_reg <= 1'b0;
            addrMode_reg <= AM_INHERENT;
            instrId_reg <= '0;
            instrGroup_reg <= GRP_LOAD;
            instrLength_reg <= '0;
            effAddr_reg <= '0;
            immValue_reg <= '0;
            branchTarget_reg <= '0;
            nextPc_reg <= '0;
        end else begin
            done_reg <= state_reg == ST_FINISH;
            if (state_reg == ST_FINISH) begin
                illegalOut_reg <= illegal_reg;
                useYOut_reg <= useY_reg;
                addrMode_reg <= mode_reg;
                instrId_reg <= id_reg;
                instrGroup_reg <= group_of(id_reg);
                instrLength_reg <= lenCount_reg;
                effAddr_reg <= eaNext;
                immValue_reg <= argWord_reg[7:0];
                branchTarget_reg <= fetchPc_reg +
                    {{(ADDR_W-8){relOff[7]}}, relOff};
                nextPc_reg <= fetchPc_reg;
            end
        end
    end

    // Control instructions: request pulses and interrupt mask level
    always_ff @(posedge clk_sys or negedge rstInt_n) begin
        if (!rstInt_n) begin
            trap_reg <= 1'b0;
            wait_reg <= 1'b0;
            halt_reg <= 1'b0;
            intMask_reg <= MASK_RESET;
        end else begin
            trap_reg <= 1'b0;
            wait_reg <= 1'b0;
            halt_reg <= 1'b0;
            if (state_reg == ST_FINISH && !illegal_reg) begin
                trap_reg <= id_reg == ID_TRAP;
                wait_reg <= id_reg == ID_WAIT_FOR_INTERRUPT;
                halt_reg <= id_reg == ID_HALT;
                if (id_reg == ID_SET_INTERRUPT_MASK) begin
                    intMask_reg <= MASK_LEVEL3;
                end else if (id_reg == ID_CLEAR_INTERRUPT_MASK) begin
                    intMask_reg <= MASK_LEVEL0;
                end
            end
        end
    end

    assign memReq = memReq_reg;
    assign memAddr = memAddr_reg;
    assign busy = busy_reg;
    assign done = done_reg;
    assign illegal = illegalOut_reg;
    assign addrMode = addrMode_reg;
    assign instrId = instrId_reg;
    assign instrGroup = instrGroup_reg;
    assign useY = useYOut_reg;
    assign instrLength = instrLength_reg;
    assign effAddr = effAddr_reg;
    assign immValue = immValue_reg;
    assign branchTarget = branchTarget_reg;
    assign nextPc = nextPc_reg;
    assign trapReq = trap_reg;
    assign waitReq = wait_reg;
    assign haltReq = halt_reg;
    assign intMask = intMask_reg;
endmodule

// ===== verification/cpu_addressing_mode_decoder_asserts.sv
/* Checker of the decoder's fetch handshake and result timing.
   Sees only the top module's ports; bound after the module. */
module cpu_addressing_mode_decoder_chk #(
    parameter int ADDR_W = 16
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [ADDR_W-1:0] startPc,
    input wire logic memAck,
    input wire logic memReq,
    input wire logic [ADDR_W-1:0] memAddr,
    input wire logic busy,
    input wire logic done,
    input wire logic illegal,
    input wire logic [2:0] instrLength,
    input wire logic trapReq,
    input wire logic waitReq,
    input wire logic haltReq,
    input wire logic [1:0] intMask
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Accepted start, and last read followed by idle bus
    sequence s_go;
        start && !busy;
    endsequence
    sequence s_last;
        memReq && memAck ##1 !memReq;
    endsequence
    go_fetch_a:
        assert property (s_go |=> busy && memReq && memAddr == $past(startPc))
        else $error("first fetch missing");
    req_hold_a:
        assert property (memReq && !memAck |=> memReq && $stable(memAddr))
        else $error("request not held");
    last_done_a:
        assert property (s_last |=> done) else $error("done late");
    done_pulse_a: assert property (done |=> !done) else $error("long done");
    done_idle_a: assert property (done |-> !busy) else $error("busy at done");
    req_busy_a: assert property (memReq |-> busy) else $error("idle request");
    len_range_a:
        assert property (done |-> instrLength inside {[1:4]})
        else $error("bad length");
    ctl_pulse_a:
        assert property (trapReq || waitReq || haltReq |-> done && !illegal)
        else $error("stray control pulse");
    mask_move_a:
        assert property (!$stable(intMask) |-> done && !illegal)
        else $error("mask moved alone");
endmodule
bind cpu_addressing_mode_decoder cpu_addressing_mode_decoder_chk #(
    .ADDR_W(ADDR_W)) chk_i (.clk_sys, .rst_n, .start, .startPc, .memAck,
    .memReq, .memAddr, .busy, .done, .illegal, .instrLength, .trapReq,
    .waitReq, .haltReq, .intMask);

// ===== verification/code_memory_model.sv
/* Byte memory on the core bus, one ack per held request.
   Assumes requests stay up until acknowledged. */
module code_memory_model (
    input wire logic clk_sys,
    input wire logic memReq,
    input wire logic [15:0] memAddr,
    output logic memAck,
    output logic [7:0] memRdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:65535];
    // Answer a held request; data scrambled between answers
    always @(posedge clk_sys) begin
        memAck <= memReq && !memAck;
        memRdata <= (memReq && !memAck) ? mem[memAddr] : ~memRdata;
    end
    initial {memAck, memRdata} = 9'h000;
endmodule

// ===== verification/cpu_addressing_mode_decoder_tb_top.sv
/* Bench of the addressing mode decoder, one task per scenario.
   Assumes code at 1000 and pointers in page zero. */
module cpu_addressing_mode_decoder_tb_top;
    import cpu_addr_decoder_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 0, rst_n = 0, start = 0, memAck, memReq, busy, done;
    logic illegal, useY, trapReq, waitReq, haltReq;
    logic [15:0] startPc = 16'h1000, memAddr, effAddr, branchTarget, nextPc;
    logic [7:0] indexX = 8'hFF, indexY = 8'h34, memRdata, immValue;
    logic [5:0] instrId;
    logic [2:0] instrLength, pulses;
    logic [1:0] intMask;
    addr_mode_t addrMode;
    group_t instrGroup;
    int fails = 0, n_compared = 0, i;
    always #10 clk_sys = ~clk_sys;
    cpu_addressing_mode_decoder dut (.clk_sys, .rst_n, .start, .startPc,
        .indexX, .indexY, .memAck, .memRdata, .memReq, .memAddr, .busy,
        .done, .illegal, .addrMode, .instrId, .instrGroup, .useY,
        .instrLength, .effAddr, .immValue, .branchTarget, .nextPc,
        .trapReq, .waitReq, .haltReq, .intMask);
    code_memory_model mem_i (.clk_sys, .memReq, .memAddr, .memAck,
        .memRdata);
    task automatic check(input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("Error %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic go(input logic [31:0] code);
        int k;
        for (k = 0; k < 4; k++) mem_i.mem[16'h1000 + k] = code[31-8*k -: 8];
        @(negedge clk_sys) start = 1;
        @(negedge clk_sys) start = 0;
        for (k = 0; k < 40 && done !== 1'b1; k++) @(negedge clk_sys);
        check(16'(done), 16'h0001);
        pulses = {trapReq, waitReq, haltReq};
    endtask
    task automatic run(input logic [31:0] code, input int len,
            input addr_mode_t m, input int ea);
        go(code);
        check(16'(instrLength), 16'(len));
        check(16'(addrMode), 16'(m));
        check(effAddr, 16'(ea));
        check(nextPc, 16'h1000 + 16'(len));
    endtask
    task automatic t_inherent;
        for (i = 1; i < 4; i++) begin
            run({i[7:0], 24'h0}, 1, AM_INHERENT, 0);
            check(16'(pulses), 16'(1 << (3 - i)));
        end
        check(16'(instrGroup), 16'(GRP_INTERRUPT));
        run(32'h07000000, 1, AM_INHERENT, 0);
        check(16'(intMask), 16'h0002);
        run(32'h06000000, 1, AM_INHERENT, 0);
        check(16'(intMask), 16'h0003);
        $display("inherent test ended");
    endtask
    task automatic t_direct;
        run(32'h20550000, 2, AM_IMMEDIATE, 0);
        check(16'(immValue), 16'h0055);
        run(32'h40A70000, 2, AM_DIR_SHORT, 16'h00A7);
        run(32'h60123400, 3, AM_DIR_LONG, 16'h1234);
        run(32'h80000000, 1, AM_IDX_NONE, 16'h00FF);
        run(32'hA0FF0000, 2, AM_IDX_SHORT, 16'h01FE);
        run(32'hC0FFF000, 3, AM_IDX_LONG, 16'h00EF);
        run(32'h90800000, 2, AM_IDX_NONE, 16'h0034);
        check(16'(useY), 16'h0001);
        $display("direct and indexed test ended");
    endtask
    task automatic t_indirect;
        mem_i.mem[16'h0040] = 8'h77;
        mem_i.mem[16'h0041] = 8'h88;
        run(32'h92404000, 3, AM_IND_SHORT, 16'h0077);
        run(32'h92604000, 3, AM_IND_LONG, 16'h7788);
        run(32'h92A04000, 3, AM_INDIDX_SHORT, 16'h0176);
        run(32'h92C04000, 3, AM_INDIDX_LONG, 16'h7887);
        run(32'h91A04000, 3, AM_INDIDX_SHORT, 16'h00AB);
        check(16'(useY), 16'h0001);
        $display("indirect test ended");
    endtask
    task automatic t_relative;
        run(32'hE0FE0000, 2, AM_REL_DIR, 0);
        check(branchTarget, 16'h1000);
        run(32'hF3050000, 2, AM_REL_DIR, 0);
        check(16'(instrId), 16'(ID_RELATIVE_SUBROUTINE_CALL));
        check(branchTarget, 16'h1007);
        run(32'h92E04000, 3, AM_REL_IND, 0);
        check(branchTarget, 16'h107A);
        run(32'h57A70000, 2, AM_BIT_DIR, 16'h00A7);
        run(32'h92574000, 3, AM_BIT_IND, 16'h0077);
        run(32'h59400500, 3, AM_BITREL_DIR, 16'h0040);
        check(branchTarget, 16'h1008);
        run(32'h92594005, 4, AM_BITREL_IND, 16'h0077);
        check(branchTarget, 16'h1009);
        $display("relative test ended");
    endtask
    task automatic t_short_only;
        go(32'h41100000);
        check(16'(illegal), 16'h0000);
        go(32'h61000000);
        check(16'(illegal), 16'h0001);
        go(32'hDC000000);
        check(16'(illegal), 16'h0001);
        go(32'h37000000);
        check(16'(illegal), 16'h0001);
        $display("short form test ended");
    endtask
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Reset, then the scenarios in turn
    initial begin
        repeat (12) @(negedge clk_sys);
        rst_n = 1;
        repeat (3) @(negedge clk_sys);
        t_inherent;
        t_direct;
        t_indirect;
        t_relative;
        t_short_only;
        stop_test;
    end
    // Watchdog well beyond the expected run
    initial begin
        #200000;
        fails++;
        stop_test;
    end
endmodule
